// ---- hdl/arith_logic_branch_exec.sv ----
// Execution datapath for add, page jump, AND, compare, clear, invert, BCD fix
`default_nettype none
module arith_logic_branch_exec (
  input  wire logic             CLK_SYS,
  input  wire logic             RST_B,
  input  wire exec_pkg::instr_s INSTR,
  input  wire logic [7:0]       ACC_IN,
  input  wire exec_pkg::flags_s FLAGS_IN,
  output exec_pkg::result_s     RESULT,
  output logic                  BUSY
);
  // ==========================================================
  // State
  typedef enum logic [0:0] {IDLE, SECOND} phase_e;

  typedef struct packed {
    phase_e            phase;
    logic              busy;
    exec_pkg::result_s res;
    exec_pkg::result_s held;
  } state_s;

  state_s st;
  state_s next_st;

  // ==========================================================
  // Helpers
  function automatic logic is_add(input logic [7:0] op);
    is_add = (op[7:4] == 4'h2 || op[7:4] == 4'h3) &&
             (op[3:0] >= 4'h4);
  endfunction : is_add

  function automatic logic [1:0] op_len(input logic [7:0] op);
    if (op[3:0] == 4'h4 || op[3:0] == 4'h5)
      op_len = exec_pkg::LEN_TWO;
    else
      op_len = exec_pkg::LEN_ONE;
  endfunction : op_len

  // ==========================================================
  // Arithmetic units
  logic [7:0]       sum;
  exec_pkg::flags_s sum_flags;
  logic [7:0]       bcd_acc;
  logic             bcd_c;
  logic             cin;

  // Plain sum drops the carry; with-carry forms feed it in
  assign cin = INSTR.opcode[4] & FLAGS_IN.carry;

  sum_unit u_sum (
    .a     (ACC_IN),
    .b     (INSTR.operand),
    .cin   (cin),
    .sum   (sum),
    .flags (sum_flags)
  );

  bcd_unit u_bcd (
    .acc    (ACC_IN),
    .cin    (FLAGS_IN.carry),
    .result (bcd_acc),
    .cout   (bcd_c)
  );

  // ==========================================================
  // Decode and execute
  logic [15:0] pc_after;
  logic [15:0] pc_after3;
  logic [7:0]  cmp_left;
  logic [7:0]  cmp_right;

  always_comb begin
    next_st       = st;
    next_st.res.done    = 1'b0;
    next_st.res.pc_load = 1'b0;
    next_st.res.mem_we  = 1'b0;
    next_st.res.bit_we  = 1'b0;
    pc_after      = INSTR.pc + 16'h0002;
    pc_after3     = INSTR.pc + 16'h0003;
    cmp_left      = (INSTR.opcode[3:0] >= 4'h6) ?
                    INSTR.operand : ACC_IN;
    cmp_right     = (INSTR.opcode[3:0] == 4'h5) ?
                    INSTR.operand : INSTR.immediate_byte;

    case (st.phase)
      IDLE: begin
        if (INSTR.valid) begin
          next_st.held        = st.res;
          next_st.held.acc    = ACC_IN;
          next_st.held.flags  = FLAGS_IN;
          next_st.held.mem_we = 1'b0;
          next_st.held.bit_we = 1'b0;
          next_st.held.pc_load = 1'b0;
          next_st.held.pc_next = pc_after;
          next_st.held.length  = op_len(INSTR.opcode);
          next_st.held.cycles  = exec_pkg::CYC_ONE;
          next_st.held.done    = 1'b1;
          next_st.held.mem_data = INSTR.operand;
          next_st.held.bit_data = INSTR.bit_value;

          if (is_add(INSTR.opcode)) begin
            next_st.held.acc   = sum;
            next_st.held.flags = sum_flags;
          end else if (INSTR.opcode[4:0] == exec_pkg::PAGE_JUMP_LO) begin
            next_st.held.pc_load = 1'b1;
            next_st.held.pc_next = {pc_after[15:exec_pkg::PAGE_BITS],
                                    INSTR.opcode[7:5],
                                    INSTR.immediate_byte};
            next_st.held.length  = exec_pkg::LEN_TWO;
            next_st.held.cycles  = exec_pkg::CYC_TWO;
          end else if (INSTR.opcode[7:4] == 4'h5 &&
                       INSTR.opcode[3:0] >= 4'h2) begin
            case (INSTR.opcode)
              exec_pkg::OP_AND_DIR_A: begin
                next_st.held.mem_we   = 1'b1;
                next_st.held.length   = exec_pkg::LEN_TWO;
                next_st.held.mem_data = INSTR.operand & ACC_IN;
              end
              exec_pkg::OP_AND_DIR_I: begin
                next_st.held.mem_we   = 1'b1;
                next_st.held.mem_data = INSTR.operand &
                                        INSTR.immediate_byte;
                next_st.held.length   = exec_pkg::LEN_THREE;
                next_st.held.cycles   = exec_pkg::CYC_TWO;
              end
              exec_pkg::OP_AND_A_IMM:
                next_st.held.acc = ACC_IN & INSTR.immediate_byte;
              default:
                next_st.held.acc = ACC_IN & INSTR.operand;
            endcase
            if (INSTR.opcode == exec_pkg::OP_AND_DIR_I ||
                INSTR.opcode == exec_pkg::OP_AND_DIR_A)
              next_st.held.acc = ACC_IN;
            if (INSTR.opcode[3:0] >= 4'h6)
              next_st.held.length = exec_pkg::LEN_ONE;
          end else if (INSTR.opcode[7:4] == 4'hB &&
                       INSTR.opcode[3:0] >= 4'h4) begin
            // Compare: carry updated whether or not the branch is taken
            next_st.held.flags.carry = cmp_left < cmp_right;
            next_st.held.pc_next = pc_after3;
            if (cmp_left != cmp_right) begin
              next_st.held.pc_load = 1'b1;
              next_st.held.pc_next = pc_after3 +
                                     {{8{INSTR.rel[7]}}, INSTR.rel};
            end
            next_st.held.length = exec_pkg::LEN_THREE;
            next_st.held.cycles = exec_pkg::CYC_TWO;
          end else begin
            case (INSTR.opcode)
              exec_pkg::OP_AND_C_BIT:
                next_st.held.flags.carry = FLAGS_IN.carry &
                                           INSTR.bit_value;
              exec_pkg::OP_AND_C_NB:
                next_st.held.flags.carry = FLAGS_IN.carry &
                                           ~INSTR.bit_value;
              exec_pkg::OP_CLR_BIT: begin
                next_st.held.bit_we   = 1'b1;
                next_st.held.bit_data = 1'b0;
              end
              exec_pkg::OP_CLR_C:
                next_st.held.flags.carry = 1'b0;
              exec_pkg::OP_CLR_A:
                next_st.held.acc = 8'h00;
              exec_pkg::OP_CPL_BIT: begin
                next_st.held.bit_we   = 1'b1;
                // Port bits use the latch so a loaded pin cannot flip it
                next_st.held.bit_data = INSTR.bit_is_port ?
                                        ~INSTR.port_latch :
                                        ~INSTR.bit_value;
              end
              exec_pkg::OP_CPL_C:
                next_st.held.flags.carry = ~FLAGS_IN.carry;
              exec_pkg::OP_CPL_A:
                next_st.held.acc = ACC_IN ^ 8'hFF;
              exec_pkg::OP_BCD_FIX: begin
                next_st.held.acc = bcd_acc;
                next_st.held.flags.carry = bcd_c;
              end
              default:
                next_st.held.done = 1'b0;
            endcase
            next_st.held.length =
              (INSTR.opcode == exec_pkg::OP_CLR_BIT ||
               INSTR.opcode == exec_pkg::OP_CPL_BIT ||
               INSTR.opcode == exec_pkg::OP_AND_C_BIT ||
               INSTR.opcode == exec_pkg::OP_AND_C_NB) ?
              exec_pkg::LEN_TWO : exec_pkg::LEN_ONE;
          end

          // Two-cycle forms hold their result until the second cycle
          if (next_st.held.cycles == exec_pkg::CYC_TWO) begin
            next_st.phase = SECOND;
          end else begin
            next_st.res = next_st.held;
          end
        end
      end
      SECOND: begin
        next_st.res   = st.held;
        next_st.phase = IDLE;
      end
      default: next_st.phase = IDLE;
    endcase
    // Busy kept as its own state bit so the output needs no decode
    next_st.busy = (next_st.phase == SECOND);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st          <= '0;
      st.phase    <= IDLE;
      st.res.acc  <= exec_pkg::ACC_RST;
      st.res.pc_next <= exec_pkg::PC_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign RESULT = st.res;
  assign BUSY   = st.busy;
endmodule : arith_logic_branch_exec
`default_nettype wire

// ---- hdl/exec_pkg.sv ----
// Package: opcodes, flag layout, reset values and carriers for the exec slice
// Function
// - Plain sum adds operand to accumulator, result to accumulator, operand kept.
// - Sum with carry also adds the carry flag; plain sum ignores it.
// - Carry set when total exceeds 255, carry out of bit 7.
// - Half carry set when low nibbles plus carry exceed 15.
// - Overflow set when exactly one of carries out of bits 6, 7 occurs.
// - Page jump: low byte from second byte, high bits 0-2 from opcode 5-7.
// - Page jump alters only the lower eleven program counter bits.
// - Kept upper bits come from the address after the two-byte jump.
// - Byte AND writes result to first operand, second operand kept.
// - Compare branches when operands differ, else falls through.
// - Compare sets carry when first operand is unsigned-less than second.
// - Clear zeroes a single bit target or all accumulator bits.
// - Complement toggles a single bit or inverts all accumulator bits.
// - Complementing a port bit uses the output latch, not the pin.
// - Decimal adjust step one adds 0x06 when carry or low nibble above 9.
// - Step two adds 0x60 when carry was set or step one corrected.
// - Decimal adjust sets carry when result exceeds 0x99, else clears.
`default_nettype none
package exec_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_ADD_IMM   = 8'h24;
  localparam logic [7:0] OP_ADD_DIR   = 8'h25;
  localparam logic [7:0] OP_SUM_WITH_CARRY_IN_IMM  = 8'h34;
  localparam logic [7:0] OP_SUM_WITH_CARRY_IN_DIR  = 8'h35;
  localparam logic [7:0] OP_AND_DIR_A = 8'h52;
  localparam logic [7:0] OP_AND_DIR_I = 8'h53;
  localparam logic [7:0] OP_AND_A_IMM = 8'h54;
  localparam logic [7:0] OP_AND_A_DIR = 8'h55;
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NB  = 8'hB0;
  localparam logic [7:0] OP_CPL_BIT   = 8'hB2;
  localparam logic [7:0] OP_CPL_C     = 8'hB3;
  localparam logic [7:0] OP_CMP_A_IMM = 8'hB4;
  localparam logic [7:0] OP_CMP_A_DIR = 8'hB5;
  localparam logic [7:0] OP_CLR_BIT   = 8'hC2;
  localparam logic [7:0] OP_CLR_C     = 8'hC3;
  localparam logic [7:0] OP_BCD_FIX   = 8'hD4;
  localparam logic [7:0] OP_CLR_A     = 8'hE4;
  localparam logic [7:0] OP_CPL_A     = 8'hF4;
  localparam logic [4:0] PAGE_JUMP_LO = 5'h01;
  // ==========================================================
  // Decimal adjust constants
  localparam logic [3:0] BCD_NIB_MAX  = 4'h9;
  localparam logic [7:0] BCD_LO_FIX   = 8'h06;
  localparam logic [7:0] BCD_HI_FIX   = 8'h60;
  localparam logic [7:0] BCD_MAX      = 8'h99;
  // ==========================================================
  // Program counter split and timing
  localparam int         PAGE_BITS    = 11;
  localparam logic [1:0] CYC_ONE      = 2'h1;
  localparam logic [1:0] CYC_TWO      = 2'h2;
  localparam logic [1:0] LEN_ONE      = 2'h1;
  localparam logic [1:0] LEN_TWO      = 2'h2;
  localparam logic [1:0] LEN_THREE    = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [15:0] PC_RST      = 16'h0000;

  typedef struct packed {
    logic        carry;
    logic        half_carry_flag;
    logic        signed_overflow_flag;
  } flags_s;

  // Instruction as presented by decode: opcode, bytes, operands
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [7:0]  immediate_byte;
    logic [7:0]  operand;
    logic        bit_value;
    logic        bit_is_port;
    logic        port_latch;
    logic [7:0]  rel;
    logic [15:0] pc;
  } instr_s;

  // Results returned to the core
  typedef struct packed {
    logic [7:0]  acc;
    flags_s      flags;
    logic        mem_we;
    logic [7:0]  mem_data;
    logic        bit_we;
    logic        bit_data;
    logic        pc_load;
    logic [15:0] pc_next;
    logic [1:0]  length;
    logic [1:0]  cycles;
    logic        done;
  } result_s;
endpackage : exec_pkg
`default_nettype wire

// ---- hdl/sum_unit.sv ----
// Sum unit: 8-bit add with carry, half carry and overflow
`default_nettype none
module sum_unit (
  input  wire logic [7:0]   a,
  input  wire logic [7:0]   b,
  input  wire logic         cin,
  output logic [7:0]        sum,
  output exec_pkg::flags_s  flags
);
  logic [4:0] lo;
  logic [7:0] lo7;
  logic [8:0] full;

  always_comb begin
    lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    lo7   = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    sum   = full[7:0];
    flags.carry                = full[8];
    flags.half_carry_flag      = lo[4];
    flags.signed_overflow_flag = full[8] ^ lo7[7];
  end
endmodule : sum_unit
`default_nettype wire

// ---- hdl/bcd_unit.sv ----
// Decimal adjust unit for the accumulator
`default_nettype none
module bcd_unit (
  input  wire logic [7:0] acc,
  input  wire logic       cin,
  output logic [7:0]      result,
  output logic            cout
);
  logic       step1;
  logic [8:0] s1;
  logic [8:0] s2;

  always_comb begin
    step1  = cin || (acc[3:0] > exec_pkg::BCD_NIB_MAX);
    s1     = {1'b0, acc} + (step1 ? {1'b0, exec_pkg::BCD_LO_FIX} : 9'h000);
    s2     = s1 + ((cin || step1) ?
             {1'b0, exec_pkg::BCD_HI_FIX} : 9'h000);
    result = s2[7:0];
    // Compares the full adjusted total so a wrap past 0xFF still sets carry
    cout   = s2 > {1'b0, exec_pkg::BCD_MAX};
  end
endmodule : bcd_unit
`default_nettype wire

// ---- test/exec_properties.sv ----
// Checker: timing and result relations of the exec datapath
`default_nettype none
module exec_properties (
  input wire logic              CLK_SYS,
  input wire logic              RST_B,
  input wire exec_pkg::instr_s  INSTR,
  input wire logic [7:0]        ACC_IN,
  input wire exec_pkg::flags_s  FLAGS_IN,
  input wire exec_pkg::result_s RESULT,
  input wire logic              BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Helpers
  logic        take;
  logic [7:0]  op;
  logic        cin;
  logic [8:0]  tot;
  logic [4:0]  nib;
  logic [7:0]  low;
  logic [15:0] pc2;
  logic [15:0] pj;
  logic [15:0] ct;
  assign take = INSTR.valid && !BUSY;
  assign op   = INSTR.opcode;
  assign cin  = FLAGS_IN.carry && op[4];
  assign tot  = ACC_IN + INSTR.operand + cin;
  assign nib  = ACC_IN[3:0] + INSTR.operand[3:0] + cin;
  assign low  = ACC_IN[6:0] + INSTR.operand[6:0] + cin;
  assign pc2  = INSTR.pc + 16'h0002;
  assign pj   = {pc2[15:11], op[7:5], INSTR.immediate_byte};
  assign ct   = INSTR.pc + 16'h0003 + {{8{INSTR.rel[7]}}, INSTR.rel};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ==========
  // Assertions
  chk_add_total: assert property (
    take && op[7:5] == 3'h1 && op[3:0] == 4'h8
    |=> {RESULT.flags.carry, RESULT.acc} == $past(tot))
    else $error("sum or carry wrong");
  chk_add_half: assert property (
    take && op[7:5] == 3'h1 && op[3:0] == 4'h8
    |=> RESULT.flags.half_carry_flag == $past(nib[4]))
    else $error("half carry wrong");
  chk_add_overflow: assert property (
    take && op[7:5] == 3'h1 && op[3:0] == 4'h8
    |=> RESULT.flags.signed_overflow_flag == $past(low[7] ^ tot[8]))
    else $error("overflow wrong");
  chk_page_target: assert property (
    take && op[4:0] == 5'h01
    |-> ##2 RESULT.pc_load && RESULT.pc_next == $past(pj, 2))
    else $error("page jump target wrong");
  chk_cmp_branch: assert property (
    take && op == 8'hB4 |-> ##2 RESULT.done
    && RESULT.pc_load == $past(ACC_IN != INSTR.immediate_byte, 2)
    && RESULT.flags.carry == $past(ACC_IN < INSTR.immediate_byte, 2)
    && (!RESULT.pc_load || RESULT.pc_next == $past(ct, 2)))
    else $error("compare outcome wrong");
  chk_two_cycle: assert property (
    take && (op[4:0] == 5'h01 || op == 8'h53 || op == 8'hB4
    || op == 8'hB8) |=> BUSY && !RESULT.done ##1 !BUSY && RESULT.done)
    else $error("two cycle timing wrong");
  chk_one_cycle: assert property (
    take && op == 8'hE4 |=> RESULT.done && !BUSY
    && RESULT.acc == 8'h00 && RESULT.cycles == exec_pkg::CYC_ONE)
    else $error("clear accumulator wrong");
  chk_invert_acc: assert property (
    take && op == 8'hF4 |=> RESULT.done && RESULT.acc == ~$past(ACC_IN))
    else $error("invert accumulator wrong");
  chk_and_carry: assert property (
    take && op == 8'hB0 |=> RESULT.flags.carry
    == ($past(FLAGS_IN.carry) && !$past(INSTR.bit_value)))
    else $error("carry and inverted bit wrong");
  cover property (take && op == 8'hD4);
  cover property (RESULT.pc_load);
  cover property (take && op[4:0] == 5'h01);
endmodule : exec_properties
bind arith_logic_branch_exec exec_properties i_exec_properties (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .INSTR(INSTR), .ACC_IN(ACC_IN),
  .FLAGS_IN(FLAGS_IN), .RESULT(RESULT), .BUSY(BUSY));
`default_nettype wire

// ---- test/core_feed_model.sv ----
// Partner model: core decode feeding instructions, with result forwarding
`default_nettype none
module core_feed_model (
  input  wire logic              clk,
  input  wire logic              busy,
  input  wire exec_pkg::result_s result,
  output exec_pkg::instr_s       instr,
  output logic [7:0]             acc_in,
  output exec_pkg::flags_s       flags_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]       acc;
  exec_pkg::flags_s flg;
  exec_pkg::instr_s last;
  initial begin
    instr = '0;
    last  = '0;
    acc   <= 8'h00;
    flg   <= '0;
  end
  // Forwarding lets back to back ops see the result of the previous one
  assign acc_in   = (result.done === 1'b1) ? result.acc : acc;
  assign flags_in = (result.done === 1'b1) ? result.flags : flg;
  always @(posedge clk) begin
    if (result.done === 1'b1) begin
      acc <= result.acc;
      flg <= result.flags;
    end
  end
  task automatic load(input logic [7:0] a, input exec_pkg::flags_s f);
    @(negedge clk);
    acc <= a;
    flg <= f;
  endtask : load
  // Two cycle ops hold the next request off while busy
  task automatic issue(input exec_pkg::instr_s i);
    @(negedge clk);
    while (busy === 1'b1) @(negedge clk);
    last  = i;
    instr = i;
    @(posedge clk);
  endtask : issue
  // Idle fields show the inverse of the last request, never stale data
  task automatic idle;
    @(negedge clk);
    instr = {1'b0, ~last[$bits(last)-2:0]};
  endtask : idle
endmodule : core_feed_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Testbench: scenario tasks for the exec datapath
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              CLK_SYS;
  logic              RST_B;
  exec_pkg::instr_s  INSTR;
  logic [7:0]        ACC_IN;
  exec_pkg::flags_s  FLAGS_IN;
  exec_pkg::result_s RESULT;
  logic              BUSY;
  int                err_total;
  int                n_checks;
  arith_logic_branch_exec i_arith_logic_branch_exec (.CLK_SYS(CLK_SYS),
    .RST_B(RST_B), .INSTR(INSTR), .ACC_IN(ACC_IN), .FLAGS_IN(FLAGS_IN),
    .RESULT(RESULT), .BUSY(BUSY));
  core_feed_model i_core_feed_model (.clk(CLK_SYS), .busy(BUSY),
    .result(RESULT), .instr(INSTR), .acc_in(ACC_IN), .flags_in(FLAGS_IN));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  // ==========
  // Shared tasks
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, imm, opd, input logic [2:0] b,
                     input logic [15:0] pc, input logic [7:0] rel,
                     input int cyc);
    int n;
    i_core_feed_model.issue('{1'b1, op, imm, opd, b[2], b[1], b[0], rel, pc});
    i_core_feed_model.idle();
    n = 1;
    while (RESULT.done !== 1'b1 && n < 4) begin
      @(negedge CLK_SYS);
      n++;
    end
    chk(n == cyc, "done latency");
  endtask : run
  // ==========
  // Scenarios
  task automatic t_add;
    logic [7:0]  ops [6] = '{8'h24, 8'h25, 8'h28, 8'h34, 8'h35, 8'h38};
    logic [16:0] cs [4] = '{{8'hFF, 8'h01, 1'b1}, {8'h7F, 8'h01, 1'b0},
                            {8'h80, 8'h80, 1'b1}, {8'h0F, 8'h00, 1'b1}};
    logic [7:0]  a, b, l;
    logic        c;
    logic [8:0]  t;
    logic [4:0]  h;
    foreach (ops[i]) foreach (cs[j]) begin
      {a, b, c} = cs[j];
      i_core_feed_model.load(a, '{c, ~c, ~c});
      run(ops[i], b, b, 3'h0, 16'h0000, 8'h00, 1);
      c = c & ops[i][4];
      t = a + b + c;
      h = a[3:0] + b[3:0] + c;
      l = a[6:0] + b[6:0] + c;
      chk(RESULT.acc === t[7:0] && RESULT.mem_we === 1'b0,
          "sum");
      chk(RESULT.length === (ops[i][3] ? exec_pkg::LEN_ONE
          : exec_pkg::LEN_TWO), "add length");
      chk(RESULT.flags.carry === t[8], "carry");
      chk(RESULT.flags.half_carry_flag === h[4], "half carry");
      chk(RESULT.flags.signed_overflow_flag === (l[7] ^ t[8]),
          "ovf");
    end
    $display("add test finished");
  endtask : t_add
  task automatic t_bcd;
    logic [8:0] cs [5] = '{{8'h15, 1'b0}, {8'h0A, 1'b0}, {8'h23, 1'b1},
                           {8'h9A, 1'b0}, {8'h45, 1'b1}};
    logic [8:0] t;
    logic       f;
    foreach (cs[j]) begin
      i_core_feed_model.load(cs[j][8:1], '{cs[j][0], 1'b0, 1'b0});
      run(8'hD4, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
      t = {1'b0, cs[j][8:1]};
      f = cs[j][0] || t[3:0] > 4'h9;
      if (f) t = t + 9'h006;
      if (f || cs[j][0]) t = t + 9'h060;
      chk(RESULT.acc === t[7:0], "bcd value");
      chk(RESULT.flags.carry === (t > 9'h099), "bcd carry");
    end
    // Back to back: sum then adjust on the forwarded result
    i_core_feed_model.load(8'h38, '{1'b0, 1'b0, 1'b0});
    i_core_feed_model.issue('{1'b1, 8'h28, 8'h45, 8'h45, 1'b0, 1'b0, 1'b0,
                             8'h00, 16'h0000});
    run(8'hD4, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.acc === 8'hE3 && RESULT.flags.carry === 1'b1,
        "chain");
    $display("bcd test finished");
  endtask : t_bcd
  task automatic t_page;
    for (int k = 0; k < 8; k++) begin
      run({k[2:0], 5'h01}, 8'h5A, 8'hA5, 3'h0, 16'h37FE, 8'h00, 2);
      chk(RESULT.pc_load === 1'b1
          && RESULT.pc_next === {5'h07, k[2:0], 8'h5A},
          "page");
      chk(RESULT.length === exec_pkg::LEN_TWO, "page length");
    end
    $display("page test finished");
  endtask : t_page
  task automatic t_and;
    i_core_feed_model.load(8'hCC, '{1'b1, 1'b1, 1'b1});
    run(8'h52, 8'h00, 8'hAA, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.mem_we === 1'b1 && RESULT.mem_data === 8'h88
        && RESULT.acc === 8'hCC, "and to memory");
    chk(RESULT.length === exec_pkg::LEN_TWO, "and length");
    run(8'h53, 8'h0F, 8'hAA, 3'h0, 16'h0000, 8'h00, 2);
    chk(RESULT.mem_we === 1'b1 && RESULT.mem_data === 8'h0A
        && RESULT.length === exec_pkg::LEN_THREE,
        "and imm");
    run(8'h54, 8'hF0, 8'hF0, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.acc === 8'hC0 && RESULT.mem_we === 1'b0, "and acc imm");
    run(8'h55, 8'h3C, 8'h3C, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.acc === 8'h00, "and acc direct");
    run(8'hB0, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.flags.carry === 1'b1, "carry and not bit");
    run(8'h82, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.flags === {1'b0, 1'b1, 1'b1}, "carry and bit");
    $display("and test finished");
  endtask : t_and
  task automatic t_cmp;
    logic [31:0] cs [4] = '{{8'hB4, 8'h40, 8'h41, 8'h41},
                            {8'hB4, 8'h41, 8'h41, 8'h41},
                            {8'hB5, 8'h80, 8'h7F, 8'h7F},
                            {8'hB8, 8'hFF, 8'hFF, 8'h00}};
    logic [7:0]  op, a, i, o, x, y;
    foreach (cs[j]) begin
      {op, a, i, o} = cs[j];
      x = (op == 8'hB8) ? o : a;
      y = (op == 8'hB5) ? o : i;
      i_core_feed_model.load(a, '{~(x < y), 1'b0, 1'b0});
      run(op, i, o, 3'h0, 16'h1000, 8'hF0, 2);
      chk(RESULT.flags.carry === (x < y), "compare carry");
      chk(RESULT.pc_load === (x != y) && RESULT.pc_next ===
          ((x != y) ? 16'h0FF3 : 16'h1003), "branch");
      chk(RESULT.length === exec_pkg::LEN_THREE, "cmp length");
    end
    $display("compare test finished");
  endtask : t_cmp
  task automatic t_clr_cpl;
    i_core_feed_model.load(8'h5A, '{1'b1, 1'b0, 1'b1});
    run(8'hC2, 8'h00, 8'h00, 3'h4, 16'h0000, 8'h00, 1);
    chk(RESULT.bit_we === 1'b1 && RESULT.bit_data === 1'b0
        && RESULT.flags.carry === 1'b1, "clear bit");
    run(8'hC3, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.flags === {1'b0, 1'b0, 1'b1}
        && RESULT.acc === 8'h5A, "clear carry");
    run(8'hF4, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.acc === 8'hA5, "invert acc");
    run(8'hB3, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.flags.carry === 1'b1 && RESULT.acc === 8'hA5, "inv c");
    run(8'hB2, 8'h00, 8'h00, 3'h4, 16'h0000, 8'h00, 1);
    chk(RESULT.bit_we === 1'b1 && RESULT.bit_data === 1'b0, "inv bit");
    // Pin reads low but latch holds one: result must follow the latch
    run(8'hB2, 8'h00, 8'h00, 3'h3, 16'h0000, 8'h00, 1);
    chk(RESULT.bit_data === 1'b0, "invert port latch");
    run(8'hE4, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h00, 1);
    chk(RESULT.acc === 8'h00 && RESULT.bit_we === 1'b0, "clear acc");
    $display("clear and invert test finished");
  endtask : t_clr_cpl
  initial begin
    err_total = 0;
    n_checks  = 0;
    RST_B     = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST_B = 1'b1;
    chk(RESULT === '0 && BUSY === 1'b0, "reset state");
    t_add;
    t_bcd;
    t_page;
    t_and;
    t_cmp;
    t_clr_cpl;
    complete_run;
  end
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
